// ### logic/wcs_pkg.sv
// Purpose: Shared constants and types for the word clock sync selector.
// Assumes: A 200 MHz system clock.
// Notes: Register offsets are byte addresses on the plain register port.
package wcs_pkg;
   localparam longint CLK_HZ = 200_000_000;
   localparam int PER_W = 16;
   // Register offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SYNTH_INC = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_PERIOD = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   // Control field positions.
   localparam int CTRL_AUTO = 0;
   localparam int CTRL_PREF_SER = 1;
   localparam int CTRL_HALVED = 2;
   localparam int CTRL_REDUND = 3;
   localparam int CTRL_SER_B = 4;
   // Interrupt status bits.
   localparam int EV_LOCK = 0;
   localparam int EV_LOSS = 1;
   localparam int EV_SWAP = 2;
   localparam int EV_W = 3;
   // Timing: lowest rate in Hz, speed borders and fallback borders as periods in clock cycles.
   localparam longint LOW_RATE_HZ = 32_000;
   localparam longint TIMEOUT_CYC = 2 * CLK_HZ / LOW_RATE_HZ;
   localparam longint SWITCH_MS = 1000;
   localparam longint SWITCH_CYC = SWITCH_MS * (CLK_HZ / 1000);
   localparam logic [PER_W-1:0] PER_DOUBLE = PER_W'(CLK_HZ / 70_000);
   localparam logic [PER_W-1:0] PER_QUAD = PER_W'(CLK_HZ / 140_000);
   localparam logic [17:0] PER_MID_32_44 = 18'(CLK_HZ / 38_050);
   localparam logic [17:0] PER_MID_44_48 = 18'(CLK_HZ / 46_050);
   localparam logic [PER_W-1:0] SYNC_TOL = 16'h0002;
   // Synthesis increments for the standard single speed rates.
   localparam logic [31:0] INC_32K = 32'((64'd32000 << 32) / CLK_HZ);
   localparam logic [31:0] INC_44K1 = 32'((64'd44100 << 32) / CLK_HZ);
   localparam logic [31:0] INC_48K = 32'((64'd48000 << 32) / CLK_HZ);
   localparam logic [31:0] INC_RESET = INC_48K;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

   typedef enum logic [1:0] {REF_INT, REF_WORD, REF_SER_A, REF_SER_B} wcs_ref_type;
   typedef enum logic [1:0] {LK_NONE, LK_LOCK, LK_SYNC} wcs_lock_type;
   typedef enum logic [1:0] {SPD_SINGLE, SPD_DOUBLE, SPD_QUAD} wcs_speed_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } wcs_bus_req_type;
endpackage : wcs_pkg

// ### logic/wcs_word_clock_sync.sv
// Purpose: Word clock reference selection, regeneration and serial input failover.
// Assumes: Reference pins are asynchronous and sampled by clk.
// Notes: The synthesiser is a 32-bit phase accumulator; its top bit is the internal clock.
`timescale 1ns/1ps
`default_nettype none

module wcs_edge_mon
   import wcs_pkg::*;
#(
   parameter int TIMEOUT = 12500
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic pin,
   output logic lvl,
   output logic rise,
   output logic valid,
   output logic [PER_W-1:0] period
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic lvl_reg;
   logic rise_reg;
   logic valid_reg;
   logic seen_reg;
   logic [PER_W-1:0] cnt_reg;
   logic [PER_W-1:0] period_reg;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lvl_reg <= 1'b0;
         rise_reg <= 1'b0;
      end
      else
      begin
         if (s2_reg == s3_reg)
         begin
            lvl_reg <= s3_reg;
         end
         rise_reg <= (s2_reg == s3_reg) && s3_reg && !lvl_reg;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_reg <= '0;
         period_reg <= '0;
         valid_reg <= 1'b0;
         seen_reg <= 1'b0;
      end
      else if (rise_reg)
      begin
         cnt_reg <= 16'h0001;
         seen_reg <= 1'b1;
         if (seen_reg && (int'(cnt_reg) < TIMEOUT))
         begin
            period_reg <= cnt_reg;
            valid_reg <= 1'b1;
         end
      end
      else if (int'(cnt_reg) >= TIMEOUT)
      begin
         valid_reg <= 1'b0;
         seen_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   assign lvl = lvl_reg;
   assign rise = rise_reg;
   assign valid = valid_reg;
   assign period = period_reg;
endmodule : wcs_edge_mon

////////////////////////////////////////////////////////////////////////////////

module wcs_word_clock_sync
   import wcs_pkg::*;
#(
   parameter int TIMEOUT = int'(TIMEOUT_CYC),
   parameter int SWITCH = int'(SWITCH_CYC)
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire wcs_bus_req_type bus_req,
   output logic [31:0] rdata,
   input wire logic word_clock_in,
   input wire logic serial_a_frame,
   input wire logic serial_b_frame,
   output logic word_clock_out,
   output logic lock_led,
   output logic irq
);
   logic [2:0] m_lvl;
   logic [2:0] m_rise;
   logic [2:0] m_valid;
   logic [PER_W-1:0] m_period [3];
   logic [2:0] pins;
   logic [4:0] ctrl_reg;
   logic [31:0] inc_reg;
   logic [31:0] nco_reg;
   logic nco_msb_reg;
   wcs_ref_type ref_reg;
   wcs_ref_type ref_next;
   wcs_lock_type lock_reg;
   wcs_lock_type lock_next;
   wcs_speed_type speed_next;
   logic [PER_W-1:0] per_cnt_reg;
   logic [PER_W-1:0] per_reg;
   logic [1:0] div_cnt_reg;
   logic [1:0] div_next;
   logic src_lvl;
   logic src_rise;
   logic nco_rise;
   logic ser_ok;
   logic loss;
   logic [17:0] per_norm;
   logic [31:0] fall_inc;
   logic [PER_W-1:0] per_diff;
   logic [31:0] swap_cnt_reg;
   logic swap;
   logic redundant_reg;
   logic [EV_W-1:0] ev_stat_reg;
   logic [EV_W-1:0] ev_mask_reg;
   logic [EV_W-1:0] ev_set;
   logic wr_ctrl;
   logic wr_inc;
   logic wr_stat;
   logic wr_mask;
   logic [31:0] rd_mux;
   logic wc_out_reg;
   logic lock_led_reg;
   logic irq_reg;
   logic [31:0] rdata_reg;

   assign pins = {serial_b_frame, serial_a_frame, word_clock_in};

   ////////////////////////////////////////////////////////////////////////////
   // Input monitors for word clock and both serial frame clocks.
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_mon
         wcs_edge_mon #(.TIMEOUT(TIMEOUT)) u_mon (
            .clk(clk),
            .arst_n(arst_n),
            .pin(pins[gi]),
            .lvl(m_lvl[gi]),
            .rise(m_rise[gi]),
            .valid(m_valid[gi]),
            .period(m_period[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Register port decode.
   assign wr_ctrl = bus_req.wr && (bus_req.addr == OFS_CTRL);
   assign wr_inc = bus_req.wr && (bus_req.addr == OFS_SYNTH_INC);
   assign wr_stat = bus_req.wr && (bus_req.addr == OFS_IRQ_STAT);
   assign wr_mask = bus_req.wr && (bus_req.addr == OFS_IRQ_MASK);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_reg <= CTRL_RESET;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_reg[3:0] <= bus_req.wdata[3:0];
         end
         if (swap)
         begin
            ctrl_reg[CTRL_SER_B] <= !ctrl_reg[CTRL_SER_B];
         end
         else if (wr_ctrl)
         begin
            ctrl_reg[CTRL_SER_B] <= bus_req.wdata[CTRL_SER_B];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ev_mask_reg <= MASK_RESET;
      end
      else if (wr_mask)
      begin
         ev_mask_reg <= bus_req.wdata[EV_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference selection.
   assign ser_ok = ctrl_reg[CTRL_SER_B] ? m_valid[2] : m_valid[1];

   always_comb
   begin
      ref_next = REF_INT;
      if (ctrl_reg[CTRL_AUTO] && !ctrl_reg[CTRL_PREF_SER] && m_valid[0])
      begin
         ref_next = REF_WORD;
      end
      else if (ctrl_reg[CTRL_AUTO] && ser_ok)
      begin
         ref_next = ctrl_reg[CTRL_SER_B] ? REF_SER_B : REF_SER_A;
      end
   end

   assign loss = (ref_reg != REF_INT) && (ref_next == REF_INT) && ctrl_reg[CTRL_AUTO];

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ref_reg <= REF_INT;
      end
      else
      begin
         ref_reg <= ref_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frequency synthesis, with hardware fallback on loss.
   always_comb
   begin
      per_norm = {2'b00, per_reg};
      if (speed_next == SPD_DOUBLE)
      begin
         per_norm = {1'b0, per_reg, 1'b0};
      end
      else if (speed_next == SPD_QUAD)
      begin
         per_norm = {per_reg, 2'b00};
      end
      fall_inc = INC_48K;
      if (per_norm > PER_MID_32_44)
      begin
         fall_inc = INC_32K;
      end
      else if (per_norm > PER_MID_44_48)
      begin
         fall_inc = INC_44K1;
      end
      fall_inc = fall_inc << speed_next;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         inc_reg <= INC_RESET;
      end
      else if (loss)
      begin
         inc_reg <= fall_inc;
      end
      else if (wr_inc)
      begin
         inc_reg <= bus_req.wdata;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         nco_reg <= '0;
         nco_msb_reg <= 1'b0;
      end
      else
      begin
         nco_reg <= nco_reg + inc_reg;
         nco_msb_reg <= nco_reg[31];
      end
   end

   assign nco_rise = nco_reg[31] && !nco_msb_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Source of the output clock and its period measurement.
   always_comb
   begin
      src_lvl = nco_reg[31];
      src_rise = nco_rise;
      case (ref_reg)
         REF_WORD:
         begin
            src_lvl = m_lvl[0];
            src_rise = m_rise[0];
         end
         REF_SER_A:
         begin
            src_lvl = m_lvl[1];
            src_rise = m_rise[1];
         end
         REF_SER_B:
         begin
            src_lvl = m_lvl[2];
            src_rise = m_rise[2];
         end
         default:
         begin
            src_lvl = nco_reg[31];
            src_rise = nco_rise;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         per_cnt_reg <= '0;
         per_reg <= '0;
      end
      else if (src_rise)
      begin
         per_cnt_reg <= 16'h0001;
         per_reg <= per_cnt_reg;
      end
      else if (per_cnt_reg != 16'hffff)
      begin
         per_cnt_reg <= per_cnt_reg + 16'h0001;
      end
   end

   always_comb
   begin
      speed_next = SPD_SINGLE;
      if (per_reg != '0 && per_reg < PER_QUAD)
      begin
         speed_next = SPD_QUAD;
      end
      else if (per_reg != '0 && per_reg < PER_DOUBLE)
      begin
         speed_next = SPD_DOUBLE;
      end
   end

   assign div_next = ctrl_reg[CTRL_HALVED] ? 2'(speed_next) : 2'b00;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         div_cnt_reg <= '0;
      end
      else if (src_rise)
      begin
         div_cnt_reg <= div_cnt_reg + 2'b01;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wc_out_reg <= 1'b0;
      end
      else if (div_next == 2'b00)
      begin
         wc_out_reg <= src_lvl;
      end
      else if (src_rise)
      begin
         wc_out_reg <= (div_next == 2'b01) ? !div_cnt_reg[0] : (div_cnt_reg == 2'b11);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lock state and lamp.
   assign per_diff = (m_period[0] > m_period[1]) ? m_period[0] - m_period[1] :
                     m_period[1] - m_period[0];

   always_comb
   begin
      lock_next = LK_NONE;
      if (ref_next != REF_INT)
      begin
         lock_next = LK_LOCK;
         if (m_valid[0] && m_valid[1] && per_diff <= SYNC_TOL)
         begin
            lock_next = LK_SYNC;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lock_reg <= LK_NONE;
         lock_led_reg <= 1'b0;
      end
      else
      begin
         lock_reg <= lock_next;
         lock_led_reg <= (lock_next != LK_NONE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial input redundancy.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         swap_cnt_reg <= '0;
         redundant_reg <= 1'b0;
      end
      else if (ctrl_reg[CTRL_REDUND] && !ser_ok &&
               (ctrl_reg[CTRL_SER_B] ? m_valid[1] : m_valid[2]))
      begin
         swap_cnt_reg <= swap ? '0 : swap_cnt_reg + 32'h0000_0001;
         redundant_reg <= redundant_reg || swap;
      end
      else
      begin
         swap_cnt_reg <= '0;
         redundant_reg <= redundant_reg && ctrl_reg[CTRL_REDUND];
      end
   end

   assign swap = ctrl_reg[CTRL_REDUND] && (int'(swap_cnt_reg) >= SWITCH - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, set wins over clear.
   assign ev_set[EV_LOCK] = (lock_next != LK_NONE) && (lock_reg == LK_NONE);
   assign ev_set[EV_LOSS] = loss;
   assign ev_set[EV_SWAP] = swap && !ser_ok;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ev_stat_reg <= '0;
         irq_reg <= 1'b0;
      end
      else
      begin
         ev_stat_reg <= (ev_stat_reg & ~(wr_stat ? bus_req.wdata[EV_W-1:0] : 3'h0)) | ev_set;
         irq_reg <= |(((ev_stat_reg & ~(wr_stat ? bus_req.wdata[EV_W-1:0] : 3'h0)) | ev_set)
                      & ev_mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, valid only in the cycle after the read strobe.
   always_comb
   begin
      case (bus_req.addr)
         OFS_CTRL: rd_mux = {27'h0, ctrl_reg};
         OFS_SYNTH_INC: rd_mux = inc_reg;
         OFS_STATUS: rd_mux = {22'h0, m_valid, redundant_reg, 2'(speed_next),
                               2'(lock_reg), 2'(ref_reg)};
         OFS_PERIOD: rd_mux = {16'h0, per_reg};
         OFS_IRQ_STAT: rd_mux = {29'h0, ev_stat_reg};
         OFS_IRQ_MASK: rd_mux = {29'h0, ev_mask_reg};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata_reg <= '0;
      end
      else
      begin
         rdata_reg <= bus_req.rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign rdata = rdata_reg;
   assign word_clock_out = wc_out_reg;
   assign lock_led = lock_led_reg;
   assign irq = irq_reg;
endmodule : wcs_word_clock_sync

`default_nettype wire

// ### verif/wcs_monitor.sv
// Purpose: Port checks for the word clock sync selector.
// Assumes: One clock domain, reset arst_n.
// Notes: Control and mask are shadowed from bus writes.
`timescale 1ns/1ps
`default_nettype none
module wcs_word_clock_sync_monitor
   import wcs_pkg::*;
#(
   parameter int TIMEOUT = 12500,
   parameter int SWITCH = 200000000
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire wcs_bus_req_type bus_req,
   input wire logic [31:0] rdata,
   input wire logic word_clock_in,
   input wire logic serial_a_frame,
   input wire logic serial_b_frame,
   input wire logic word_clock_out,
   input wire logic lock_led,
   input wire logic irq
);
   logic [4:0] ctrl_reg;
   logic [2:0] mask_reg;
   logic [2:0] pin_reg;
   logic out_reg;
   logic [3:0] man_reg;
   logic [3:0] lk_reg;
   logic [15:0] idle_reg;
   logic [15:0] run_reg;
   logic follow;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   assign follow = ctrl_reg[CTRL_AUTO] && !ctrl_reg[CTRL_PREF_SER]
      && !ctrl_reg[CTRL_HALVED] && lk_reg == 4'hf;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_reg <= 5'h00;
         mask_reg <= 3'h0;
      end
      else if (bus_req.wr && bus_req.addr == OFS_CTRL)
         ctrl_reg <= bus_req.wdata[4:0];
      else if (bus_req.wr && bus_req.addr == OFS_IRQ_MASK)
         mask_reg <= bus_req.wdata[2:0];
   end
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_reg <= 3'h0;
         out_reg <= 1'b0;
         man_reg <= 4'h0;
         lk_reg <= 4'h0;
         idle_reg <= 16'h0;
         run_reg <= 16'h0;
      end
      else
      begin
         pin_reg <= {word_clock_in, serial_a_frame, serial_b_frame};
         out_reg <= word_clock_out;
         man_reg <= ctrl_reg[CTRL_AUTO] ? 4'h0 : man_reg + 4'(man_reg != 4'hf);
         lk_reg <= !lock_led ? 4'h0 : lk_reg + 4'(lk_reg != 4'hf);
         idle_reg <= (pin_reg != {word_clock_in, serial_a_frame, serial_b_frame}) ? 16'h0
            : idle_reg + 16'(idle_reg != 16'hffff);
         run_reg <= (out_reg != word_clock_out) ? 16'h0 : run_reg + 16'(run_reg != 16'hffff);
      end
   end
   a_rdata_idle_zero: assert property (!$past(bus_req.rd) |-> rdata == 32'h0)
      else $error("read data not zero outside read slot");
   a_unmapped_read_zero: assert property (bus_req.rd && bus_req.addr > OFS_IRQ_MASK
      |=> rdata == 32'h0) else $error("unmapped read not zero");
   a_masked_irq_off: assert property (mask_reg == 3'h0 && $past(mask_reg) == 3'h0
      |-> !irq) else $error("irq high with all events masked");
   a_manual_no_lock: assert property (man_reg > 4'h5 |-> !lock_led)
      else $error("lock lamp lit without auto mode");
   a_idle_no_lock: assert property (idle_reg > 16'(TIMEOUT + 16) |-> !lock_led)
      else $error("lock lamp lit with silent references");
   a_output_alive: assert property (run_reg < 16'(TIMEOUT + 7000))
      else $error("word clock output stalled");
   a_rise_follow: assert property (follow && $rose(word_clock_in)
      |-> ##[2:10] $rose(word_clock_out)) else $error("output rise not in phase");
   a_fall_follow: assert property (follow && $fell(word_clock_in)
      |-> ##[2:10] $fell(word_clock_out)) else $error("output fall not in phase");
   c_lock: cover property ($rose(lock_led));
   c_irq: cover property ($rose(irq));
   c_redund: cover property (ctrl_reg[CTRL_REDUND] && lock_led);
endmodule : wcs_word_clock_sync_monitor
bind wcs_word_clock_sync wcs_word_clock_sync_monitor #(
   .TIMEOUT(TIMEOUT),
   .SWITCH(SWITCH)
) u_mon (
   .clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
   .word_clock_in(word_clock_in), .serial_a_frame(serial_a_frame),
   .serial_b_frame(serial_b_frame), .word_clock_out(word_clock_out),
   .lock_led(lock_led), .irq(irq)
);
`default_nettype wire

// ### verif/wcs_ref_src.sv
// Purpose: Far side model: word clock source and two serial frame clocks.
// Assumes: The bench sets run and half_ns by hierarchy.
// Notes: A stopped source holds its line low, like a lost clock.
`timescale 1ns/1ps
`default_nettype none
module wcs_ref_src
(
   output logic word_clock_in,
   output logic serial_a_frame,
   output logic serial_b_frame
);
   logic [2:0] pin = 3'h0;
   logic [2:0] run = 3'h0;
   int half_ns [3] = '{32, 32, 32};
   assign word_clock_in = pin[0];
   assign serial_a_frame = pin[1];
   assign serial_b_frame = pin[2];
   for (genvar i = 0; i < 3; i++)
   begin : g_src
      always
      begin
         if (run[i])
            #(half_ns[i]) pin[i] = run[i] & ~pin[i];
         else
            #4 pin[i] = 1'b0;
      end
   end
endmodule : wcs_ref_src
`default_nettype wire

// ### verif/wcs_word_clock_sync_tb_top.sv
// Purpose: Self-checking bench for the word clock sync selector.
// Assumes: Short TIMEOUT and SWITCH counts for simulation.
// Notes: Output half periods are counted at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module wcs_word_clock_sync_tb_top
   import wcs_pkg::*;
;
   localparam int TOUT = 10000;
   localparam int SW = 200;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   wcs_bus_req_type req = '0;
   logic [31:0] rdata;
   logic [31:0] d;
   logic [31:0] n;
   logic wc_in;
   logic sa;
   logic sb;
   logic wc_out;
   logic lock_led;
   logic irq;
   int num_errors = 0;
   int n_compared = 0;
   int half_tbl [3] = '{32, 5208, 11340};
   logic [31:0] per_tbl [3] = '{32'd13, 32'd2083, 32'd4536};
   logic [7:0] ra [5] = '{OFS_CTRL, OFS_SYNTH_INC, OFS_IRQ_STAT, OFS_IRQ_MASK, 8'h20};
   logic [31:0] rv [5] = '{32'h0, INC_RESET, 32'h0, 32'h0, 32'h0};
   wcs_ref_src src (.word_clock_in(wc_in), .serial_a_frame(sa), .serial_b_frame(sb));
   wcs_word_clock_sync #(.TIMEOUT(TOUT), .SWITCH(SW)) uut (
      .clk(clk), .arst_n(arst_n), .bus_req(req), .rdata(rdata), .word_clock_in(wc_in),
      .serial_a_frame(sa), .serial_b_frame(sb), .word_clock_out(wc_out),
      .lock_led(lock_led), .irq(irq)
   );
   always #2.5 clk = ~clk;
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic near(input logic [31:0] x, input logic [31:0] e);
      return x + 32'd2 >= e && x <= e + 32'd2;
   endfunction : near
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc
   task automatic lvl(input logic v);
      int k = 0;
      while (wc_out !== v && k < 20000)
      begin
         @(negedge clk);
         n++;
         k++;
      end
   endtask : lvl
   task automatic half_out(input logic [31:0] e);
      lvl(1'b0);
      lvl(1'b1);
      n = 0;
      lvl(1'b0);
      chk(32'(near(n, e)), 32'h1);
   endtask : half_out
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict
   initial
   begin
      #450000;
      num_errors++;
      give_verdict();
   end
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      wr(OFS_STATUS, 32'hffffffff);
      wr(8'h20, 32'hffffffff);
      for (int i = 0; i < 5; i++)
      begin
         rd(ra[i]);
         chk(d, rv[i]);
      end
      rd(OFS_STATUS);
      chk(d & 32'h3cf, 32'h0);
      half_out(32'd2083);
      wr(OFS_SYNTH_INC, INC_44K1);
      half_out(32'd2268);
      src.run[0] = 1'b1;
      cyc(100);
      rd(OFS_STATUS);
      chk(d & 32'h383, 32'h80);
      wr(OFS_CTRL, 32'h3);
      cyc(20);
      rd(OFS_STATUS);
      chk(32'({d[1:0], lock_led}), 32'h0);
      src.half_ns[0] = 5208;
      wr(OFS_CTRL, 32'h5);
      cyc(6300);
      half_out(32'd2083);
      src.half_ns[0] = 32;
      cyc(1200);
      half_out(32'd13);
      wr(OFS_IRQ_MASK, 32'h2);
      wr(OFS_CTRL, 32'h1);
      for (int i = 0; i < 3; i++)
      begin
         src.half_ns[0] = half_tbl[i];
         cyc(6 * half_tbl[i] / 5 + 50);
         rd(OFS_STATUS);
         chk(32'(d[9:0]), {22'h0, 4'h2, 2'(2 - i), 4'h5});
         chk(32'(lock_led), 32'h1);
         rd(OFS_PERIOD);
         chk(32'(near(d, per_tbl[i])), 32'h1);
      end
      chk(32'(irq), 32'h0);
      src.run[0] = 1'b0;
      cyc(TOUT + 200);
      chk(32'({irq, lock_led}), 32'h2);
      rd(OFS_STATUS);
      chk(32'(d[1:0]), 32'h0);
      rd(OFS_SYNTH_INC);
      chk(d, INC_44K1);
      rd(OFS_IRQ_STAT);
      chk(d, 32'h3);
      wr(OFS_IRQ_STAT, 32'h7);
      rd(OFS_IRQ_STAT);
      chk(32'({d[2:0], irq}), 32'h0);
      half_out(32'd2268);
      src.half_ns = '{32, 32, 32};
      src.run = 3'h7;
      cyc(200);
      rd(OFS_STATUS);
      chk(32'(d[3:0]), 32'h9);
      wr(OFS_CTRL, 32'hb);
      src.run = 3'h6;
      cyc(100);
      rd(OFS_STATUS);
      chk(32'(d[1:0]), 32'h2);
      src.run = 3'h4;
      cyc(TOUT + SW + 100);
      rd(OFS_STATUS);
      chk(d & 32'h43, 32'h43);
      rd(OFS_CTRL);
      chk(d, 32'h1b);
      rd(OFS_IRQ_STAT);
      chk(d & 32'h4, 32'h4);
      give_verdict();
   end
endmodule : wcs_word_clock_sync_tb_top
`default_nettype wire
